// ### design/dsi_consts.svh
// constants for the dual converter serial interface
// Operation
// - a frame is 16 bits: four command bits then a 12-bit code
// - each channel holds an input register apart from its converter register
// - shifted bits leave on serial_data_out so devices can be chained
// - readback returns the chosen channel's converter register on serial_data_out
// - reset clears the shift register and all code latches to zero
// - the link is meant for a host serial clock up to 30 MHz; at a 100 MHz sys_clk the pin filter caps it lower
// - a write goes to channel A, channel B or both
// - load-input command with load_output_n high leaves outputs until update
// - after an input load, load_output_n low moves the code to the output
// - zero-scale clear command forces both outputs to code zero
// - load-and-update writes and updates at once, ignoring load_output_n
// - falling hardware_clear_n clears both to zero or midscale per control
// - control selects the sampling clock edge; output changes on the other
// - with chaining disabled serial_data_out holds a constant level outside readback frames
`ifndef DSI_CONSTS_SVH
`define DSI_CONSTS_SVH

`define DSI_CODE_W        12
`define DSI_CMD_W         4
`define DSI_FRAME_W       16
`define DSI_CNT_W         5
`define DSI_CNT_MAX       5'h1f
`define DSI_ZERO_CODE     12'h000
`define DSI_MID_CODE      12'h800

// command codes carried in the top four bits of a frame
`define DSI_CMD_NOP       4'h0
`define DSI_CMD_LDU_A     4'h1
`define DSI_CMD_LDI_A     4'h2
`define DSI_CMD_RB_A      4'h3
`define DSI_CMD_LDU_B     4'h4
`define DSI_CMD_LDI_B     4'h5
`define DSI_CMD_RB_B      4'h6
`define DSI_CMD_LDU_AB    4'h7
`define DSI_CMD_LDI_AB    4'h8
`define DSI_CMD_CLR_ZERO  4'h9
`define DSI_CMD_CLR_MID   4'ha
`define DSI_CMD_CTRL      4'hb

// control word field positions within the 12-bit code
`define DSI_CTRL_DAISY_OFF 0
`define DSI_CTRL_CLR_MID   1
`define DSI_CTRL_RISE      2

// synchronised pin vector: bit positions and reset levels
`define DSI_PIN_N         5
`define DSI_PIN_SCLK      0
`define DSI_PIN_SDIN      1
`define DSI_PIN_FRAME     2
`define DSI_PIN_LOAD      3
`define DSI_PIN_CLR       4
`define DSI_PIN_RST       5'h1c

// timing: system clock and fastest host serial clock
`define DSI_SYS_MHZ       100
`define DSI_SCLK_MAX_MHZ  30
`define DSI_SYNC_STAGES   3

`endif

// ### design/dsi_pkg.sv
// types shared by the dual converter serial interface
package dsi_pkg;

   // one received frame, command first
   typedef struct packed {
      logic [3:0]  cmd;
      logic [11:0] code;
   } dsi_frame_t;

   // control word held by the device
   typedef struct packed {
      logic sample_rise;
      logic clear_mid;
      logic daisy_off;
   } dsi_ctrl_t;

   // per-channel strobes toward a channel register pair
   typedef struct packed {
      logic wr_input;
      logic wr_both;
      logic transfer;
      logic clear;
   } dsi_chan_ctl_t;

   typedef enum logic [1:0] {
      DSI_ST_IDLE  = 2'b01,
      DSI_ST_SHIFT = 2'b10
   } dsi_state_t;

endpackage

// ### design/dsi_chan.sv
// one channel: input register and converter register
`timescale 1ns/1ps
`include "dsi_consts.svh"
module dsi_chan
   import dsi_pkg::*;
#(
   parameter int W = `DSI_CODE_W
) (
   input  wire logic          sys_clk,
   input  wire logic          rst_b,
   input  wire dsi_chan_ctl_t ctl,
   input  wire logic [W-1:0]  code,
   input  wire logic [W-1:0]  force_code,
   output logic [W-1:0]       input_reg,
   output logic [W-1:0]       dac_reg
);

   logic [W-1:0] next_input_reg;
   logic [W-1:0] next_dac_reg;

   // clear beats any write; a new input code passes straight on transfer
   always_comb begin
      next_input_reg = input_reg;
      next_dac_reg   = dac_reg;
      if (ctl.clear) begin
         next_input_reg = force_code;
         next_dac_reg   = force_code;
      end else if (ctl.wr_both) begin
         next_input_reg = code;
         next_dac_reg   = code;
      end else begin
         if (ctl.wr_input) begin
            next_input_reg = code;
         end
         if (ctl.transfer) begin
            next_dac_reg = ctl.wr_input ? code : input_reg;
         end
      end
   end

   // both latches start at zero scale
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         input_reg <= '0;
         dac_reg   <= '0;
      end else begin
         input_reg <= next_input_reg;
         dac_reg   <= next_dac_reg;
      end
   end

endmodule

// ### design/dsi_top.sv
// serial front end of a dual 12-bit converter with double buffering
`timescale 1ns/1ps
`include "dsi_consts.svh"
module dsi_top
   import dsi_pkg::*;
#(
   parameter int CODE_W  = `DSI_CODE_W,
   parameter int FRAME_W = `DSI_FRAME_W
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   input  wire logic              serial_clk,
   input  wire logic              serial_data_in,
   input  wire logic              frame_sel_n,
   input  wire logic              load_output_n,
   input  wire logic              hardware_clear_n,
   output logic                   serial_data_out,
   output logic [CODE_W-1:0]      dac_a_code,
   output logic [CODE_W-1:0]      dac_b_code
);

   // limitation: the serial clock is oversampled, so each half period
   // must span two system clocks to clear the filter; at 100 MHz that
   // caps the link near 25 MHz, short of 30 MHz, unless sys_clk rises
   localparam int SYS_MHZ  = `DSI_SYS_MHZ;
   localparam int SCLK_MHZ = `DSI_SCLK_MAX_MHZ;

   // ---------------------------------------------------------------
   // pin synchronisers: three stages, a change counts when 2 and 3 agree
   // ---------------------------------------------------------------
   logic [`DSI_PIN_N-1:0] pin_s1;
   logic [`DSI_PIN_N-1:0] pin_s2;
   logic [`DSI_PIN_N-1:0] pin_s3;
   logic [`DSI_PIN_N-1:0] pin_filt;
   logic [`DSI_PIN_N-1:0] pin_prev;
   logic [`DSI_PIN_N-1:0] pin_raw;
   logic [`DSI_PIN_N-1:0] next_pin_filt;

   // one vector so all five pins share the same synchroniser timing
   assign pin_raw = {hardware_clear_n, load_output_n, frame_sel_n,
                     serial_data_in, serial_clk};

   // filter only accepts a level the last two stages agree on;
   // a single-clock glitch on a pin never reaches the edge detectors
   always_comb begin
      next_pin_filt = pin_filt;
      for (int i = 0; i < `DSI_PIN_N; i++) begin
         if (pin_s2[i] == pin_s3[i]) begin
            next_pin_filt[i] = pin_s3[i];
         end
      end
   end

   // reset levels equal the idle pin levels, so no false edge follows
   // reset; only s2 reads s1, the stage that may go metastable
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1   <= `DSI_PIN_RST;
         pin_s2   <= `DSI_PIN_RST;
         pin_s3   <= `DSI_PIN_RST;
         pin_filt <= `DSI_PIN_RST;
         pin_prev <= `DSI_PIN_RST;
      end else begin
         pin_s1   <= pin_raw;
         pin_s2   <= pin_s1;
         pin_s3   <= pin_s2;
         pin_filt <= next_pin_filt;
         pin_prev <= pin_filt;
      end
   end

   // edges of the filtered pins; pin_prev trails pin_filt by one clock,
   // so each edge strobe is exactly one system clock wide
   logic sclk_rise;
   logic sclk_fall;
   logic frame_start;
   logic frame_end;
   logic clr_fall;
   logic sdin;
   logic load_low;

   assign sclk_rise   = pin_filt[`DSI_PIN_SCLK] & ~pin_prev[`DSI_PIN_SCLK];
   assign sclk_fall   = ~pin_filt[`DSI_PIN_SCLK] & pin_prev[`DSI_PIN_SCLK];
   assign frame_start = ~pin_filt[`DSI_PIN_FRAME] & pin_prev[`DSI_PIN_FRAME];
   assign frame_end   = pin_filt[`DSI_PIN_FRAME] & ~pin_prev[`DSI_PIN_FRAME];
   assign clr_fall    = ~pin_filt[`DSI_PIN_CLR] & pin_prev[`DSI_PIN_CLR];
   assign sdin        = pin_filt[`DSI_PIN_SDIN];
   assign load_low    = ~pin_filt[`DSI_PIN_LOAD];

   // ---------------------------------------------------------------
   // frame engine: shift register, bit count, output bit, control word
   // ---------------------------------------------------------------
   dsi_state_t           state;
   dsi_state_t           next_state;
   dsi_frame_t           shift;
   dsi_frame_t           next_shift;
   logic [`DSI_CNT_W-1:0] bit_cnt;
   logic [`DSI_CNT_W-1:0] next_bit_cnt;
   dsi_ctrl_t            ctrl;
   dsi_ctrl_t            next_ctrl;
   logic                 rb_active;
   logic                 next_rb_active;
   logic                 next_serial_data_out;
   logic                 sample_edge;
   logic                 drive_edge;
   logic                 execute;
   logic                 sdo_enable;

   // selected sampling edge, output moves on the other one;
   // change the edge between frames only, never while one is open
   assign sample_edge = ctrl.sample_rise ? sclk_rise : sclk_fall;
   assign drive_edge  = ctrl.sample_rise ? sclk_fall : sclk_rise;

   // a frame cut short by the host leaves both channels untouched;
   // short frames are dropped; longer ones keep the last sixteen bits,
   // which is what lets a chain of devices share one frame select
   assign execute = (state == DSI_ST_SHIFT) && frame_end &&
                    (bit_cnt >= `DSI_CNT_W'(FRAME_W));

   // a readback frame drives the line even with chaining switched off;
   // otherwise the line sits low, so a chained part sees no edge
   assign sdo_enable = ~ctrl.daisy_off | rb_active;

   // code picked for readback: channel a unless channel b is asked for
   logic [CODE_W-1:0] rb_code;

   // everything holds unless an edge moves it; the shift register keeps
   // its contents between frames, which carries readback data and chained
   // bits into the next frame
   always_comb begin
      next_state           = state;
      next_shift           = shift;
      next_bit_cnt         = bit_cnt;
      next_ctrl            = ctrl;
      next_rb_active       = rb_active;
      next_serial_data_out = serial_data_out;
      rb_code              = dac_a_code;
      case (state)
         DSI_ST_IDLE: begin
            if (frame_start) begin
               next_state   = DSI_ST_SHIFT;
               next_bit_cnt = '0;
               // first bit of the frame is already on the line
               next_serial_data_out = sdo_enable & shift.cmd[3];
            end
         end
         DSI_ST_SHIFT: begin
            if (frame_end) begin
               // frame over: act on the command held in the shift register
               next_state = DSI_ST_IDLE;
               next_rb_active = 1'b0;
               if (execute) begin
                  case (shift.cmd)
                     `DSI_CMD_RB_A, `DSI_CMD_RB_B: begin
                        if (shift.cmd == `DSI_CMD_RB_B) begin
                           rb_code = dac_b_code;
                        end
                        // parked for the host to clock out next frame
                        next_shift     = {`DSI_CMD_W'(0), rb_code};
                        next_rb_active = 1'b1;
                     end
                     `DSI_CMD_CTRL: begin
                        // takes effect from the next frame on
                        next_ctrl.daisy_off =
                           shift.code[`DSI_CTRL_DAISY_OFF];
                        next_ctrl.clear_mid =
                           shift.code[`DSI_CTRL_CLR_MID];
                        next_ctrl.sample_rise =
                           shift.code[`DSI_CTRL_RISE];
                     end
                     default: begin
                     end
                  endcase
               end
            end else begin
               if (sample_edge) begin
                  // most significant bit first, command ahead of code
                  next_shift = {shift[FRAME_W-2:0], sdin};
                  // saturate so an overlong chained frame never wraps
                  if (bit_cnt != `DSI_CNT_MAX) begin
                     next_bit_cnt = bit_cnt + `DSI_CNT_W'(1);
                  end
               end
               // the bit leaving is the one pushed up by the last sample
               if (drive_edge) begin
                  next_serial_data_out =
                     sdo_enable & shift[FRAME_W-1];
               end
            end
         end
         default: begin
            // an illegal state code falls back to idle
            next_state = DSI_ST_IDLE;
         end
      endcase
      // chaining off, outside a readback frame, overrides every drive above
      if (!sdo_enable) begin
         next_serial_data_out = 1'b0;
      end
   end

   // power-up state: empty shift register, chaining on, falling edge sample
   // serial_data_out starts low, the same level as chaining switched off
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state           <= DSI_ST_IDLE;
         shift           <= '0;
         bit_cnt         <= '0;
         ctrl            <= '0;
         rb_active       <= 1'b0;
         serial_data_out <= 1'b0;
      end else begin
         state           <= next_state;
         shift           <= next_shift;
         bit_cnt         <= next_bit_cnt;
         ctrl            <= next_ctrl;
         rb_active       <= next_rb_active;
         serial_data_out <= next_serial_data_out;
      end
   end

   // ---------------------------------------------------------------
   // command decode into per-channel strobes
   // ---------------------------------------------------------------
   dsi_chan_ctl_t     ctl_a;
   dsi_chan_ctl_t     ctl_b;
   logic [CODE_W-1:0] force_code;

   // pin clear value picks zero or midscale from the control word;
   // load_output_n low copies input to converter on every clock it stays
   // low, so a long low level also carries later input writes through
   always_comb begin
      ctl_a          = '0;
      ctl_b          = '0;
      force_code     = `DSI_ZERO_CODE;
      ctl_a.transfer = load_low;
      ctl_b.transfer = load_low;
      if (execute) begin
         case (shift.cmd)
            `DSI_CMD_LDU_A:  ctl_a.wr_both = 1'b1;
            `DSI_CMD_LDI_A:  ctl_a.wr_input = 1'b1;
            `DSI_CMD_LDU_B:  ctl_b.wr_both = 1'b1;
            `DSI_CMD_LDI_B:  ctl_b.wr_input = 1'b1;
            `DSI_CMD_LDU_AB: begin
               ctl_a.wr_both = 1'b1;
               ctl_b.wr_both = 1'b1;
            end
            `DSI_CMD_LDI_AB: begin
               ctl_a.wr_input = 1'b1;
               ctl_b.wr_input = 1'b1;
            end
            `DSI_CMD_CLR_ZERO: begin
               ctl_a.clear = 1'b1;
               ctl_b.clear = 1'b1;
            end
            `DSI_CMD_CLR_MID: begin
               ctl_a.clear = 1'b1;
               ctl_b.clear = 1'b1;
               force_code  = `DSI_MID_CODE;
            end
            default: begin
            end
         endcase
      end
      // the pin clear wins over any command in the same cycle;
      // it is edge-triggered: a pin held low clears once, not each cycle
      if (clr_fall) begin
         ctl_a.clear = 1'b1;
         ctl_b.clear = 1'b1;
         force_code  = ctrl.clear_mid ? `DSI_MID_CODE : `DSI_ZERO_CODE;
      end
   end

   // ---------------------------------------------------------------
   // the two double-buffered channels; the input registers are not read
   // here, since readback returns the converter register, and a clear
   // value lands in both registers of a channel
   // ---------------------------------------------------------------
   dsi_chan #(
      .W          (CODE_W)
   ) u_chan_a (
      .sys_clk    (sys_clk),
      .rst_b      (rst_b),
      .ctl        (ctl_a),
      .code       (shift.code),
      .force_code (force_code),
      .input_reg  (),
      .dac_reg    (dac_a_code)
   );

   dsi_chan #(
      .W          (CODE_W)
   ) u_chan_b (
      .sys_clk    (sys_clk),
      .rst_b      (rst_b),
      .ctl        (ctl_b),
      .code       (shift.code),
      .force_code (force_code),
      .input_reg  (),
      .dac_reg    (dac_b_code)
   );

endmodule

// ### sim/dsi_properties.sv
// port assertions for the dual converter serial front end
`timescale 1ns/1ps
`include "dsi_consts.svh"
module dsi_props
   import dsi_pkg::*;
#(
   parameter int CODE_W = 12
) (
   input wire logic              sys_clk,
   input wire logic              rst_b,
   input wire logic              serial_clk,
   input wire logic              serial_data_in,
   input wire logic              frame_sel_n,
   input wire logic              load_output_n,
   input wire logic              hardware_clear_n,
   input wire logic              serial_data_out,
   input wire logic [CODE_W-1:0] dac_a_code,
   input wire logic [CODE_W-1:0] dac_b_code
);
   logic [3:0] ev_age, next_ev_age, pin_age, next_pin_age;
   logic       prev_fs, prev_clr, prev_sclk;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   // cycles since a cause; pins pass a filter so causes lag
   always_comb begin
      next_ev_age = (ev_age == 4'hf) ? ev_age : ev_age + 4'h1;
      next_pin_age = (pin_age == 4'hf) ? pin_age : pin_age + 4'h1;
      if ((frame_sel_n && !prev_fs) || !load_output_n ||
          (!hardware_clear_n && prev_clr)) begin
         next_ev_age = 4'h0;
      end
      if (serial_clk != prev_sclk || frame_sel_n != prev_fs) begin
         next_pin_age = 4'h0;
      end
   end

   // start saturated so a spurious change after reset is caught
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ev_age <= 4'hf;
         pin_age <= 4'hf;
         prev_fs <= 1'b1;
         prev_clr <= 1'b1;
         prev_sclk <= 1'b0;
      end else begin
         ev_age <= next_ev_age;
         pin_age <= next_pin_age;
         prev_fs <= frame_sel_n;
         prev_clr <= hardware_clear_n;
         prev_sclk <= serial_clk;
      end
   end

   sequence s_hold;
      ($stable(dac_a_code) && $stable(dac_b_code))[*3];
   endsequence
   sequence s_load_quiet;
      (!load_output_n && frame_sel_n && hardware_clear_n)[*8];
   endsequence
   sequence s_link_idle;
      (frame_sel_n && $stable(serial_clk))[*8];
   endsequence

   property p_reset_zero;
      $rose(rst_b) |-> (dac_a_code == '0 && dac_b_code == '0 &&
                        !serial_data_out)[*3];
   endproperty
   property p_a_cause;
      $changed(dac_a_code) |-> ev_age <= 4'h9;
   endproperty
   property p_b_cause;
      $changed(dac_b_code) |-> ev_age <= 4'h9;
   endproperty
   property p_clear_both;
      $fell(hardware_clear_n) && frame_sel_n |-> ##[3:9]
         (dac_a_code == dac_b_code && (dac_a_code == `DSI_ZERO_CODE ||
                                       dac_a_code == `DSI_MID_CODE));
   endproperty
   property p_frame_lag;
      $rose(frame_sel_n) && load_output_n && hardware_clear_n |-> s_hold;
   endproperty
   property p_sdo_cause;
      $changed(serial_data_out) |-> pin_age <= 4'h9;
   endproperty
   property p_load_settle;
      s_load_quiet |-> $stable(dac_a_code) && $stable(dac_b_code);
   endproperty
   property p_sdo_idle;
      s_link_idle |-> $stable(serial_data_out);
   endproperty

   a_reset_zero: assert property (p_reset_zero)
      else $error("codes not zero after reset");
   a_a_cause: assert property (p_a_cause)
      else $error("code a changed without cause");
   a_b_cause: assert property (p_b_cause)
      else $error("code b changed without cause");
   a_clear_both: assert property (p_clear_both)
      else $error("hardware clear missed");
   a_frame_lag: assert property (p_frame_lag)
      else $error("codes moved too soon after frame end");
   a_sdo_cause: assert property (p_sdo_cause)
      else $error("serial out moved without clock edge");
   a_load_settle: assert property (p_load_settle)
      else $error("codes unsettled under load");
   a_sdo_idle: assert property (p_sdo_idle)
      else $error("serial out moved while idle");
endmodule

bind dsi_top dsi_props #(.CODE_W(CODE_W)) u_props (
   .sys_clk(sys_clk), .rst_b(rst_b), .serial_clk(serial_clk),
   .serial_data_in(serial_data_in), .frame_sel_n(frame_sel_n),
   .load_output_n(load_output_n), .hardware_clear_n(hardware_clear_n),
   .serial_data_out(serial_data_out), .dac_a_code(dac_a_code),
   .dac_b_code(dac_b_code));

// ### sim/dsi_host_model.sv
// host serial port model driving the converter link
`timescale 1ns/1ps
module dsi_host_model (
   output logic      serial_clk,
   output logic      serial_data_in,
   output logic      frame_sel_n,
   input  wire logic serial_data_out,
   input  wire logic sample_rise
);
   localparam realtime HALF = 62.5; // 8 MHz, well under 30 MHz

   // idle levels the device expects across reset
   initial begin
      serial_clk = 1'b0;
      serial_data_in = 1'b0;
      frame_sel_n = 1'b1;
   end

   // one framed word, msb first, clock still outside frames; data moves
   // mid-way through the low phase so either sampling edge sees it settled
   task automatic send(input logic [15:0] word, input int nbits,
                       output logic [15:0] got);
      int i;
      got = '0;
      frame_sel_n = 1'b0;
      #(HALF);
      for (i = 15; i > 15 - nbits; i--) begin
         serial_data_in = word[i];
         #(HALF / 2.0);
         // read at the device's sampling edge, before it moves the line
         if (sample_rise) got = {got[14:0], serial_data_out};
         serial_clk = 1'b1;
         #(HALF);
         if (!sample_rise) got = {got[14:0], serial_data_out};
         serial_clk = 1'b0;
         #(HALF / 2.0);
      end
      #(HALF / 2.0);
      frame_sel_n = 1'b1;
      serial_data_in = ~serial_data_in; // released, not last value
      #(4 * HALF);
   endtask
endmodule

// ### sim/tb.sv
// self-checking bench for the dual converter serial front end
`timescale 1ns/1ps
`include "dsi_consts.svh"
module tb
   import dsi_pkg::*;
;
   logic        sys_clk = 1'b0;
   logic        rst_b, load_output_n, hardware_clear_n, host_rise;
   wire logic   serial_clk, serial_data_in, frame_sel_n, serial_data_out;
   logic [11:0] dac_a_code, dac_b_code;
   logic [15:0] rx;
   int          err_total, total_checks, cyc;

   dsi_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .serial_clk(serial_clk), .serial_data_in(serial_data_in),
      .frame_sel_n(frame_sel_n), .load_output_n(load_output_n),
      .hardware_clear_n(hardware_clear_n),
      .serial_data_out(serial_data_out),
      .dac_a_code(dac_a_code), .dac_b_code(dac_b_code));
   dsi_host_model u_host (.serial_clk(serial_clk),
      .serial_data_in(serial_data_in), .frame_sel_n(frame_sel_n),
      .serial_data_out(serial_data_out), .sample_rise(host_rise));

   always #5 sys_clk = ~sys_clk;

   task automatic close_out();
      if (err_total == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // hang guard, about 1.7 times the expected run
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 10000) begin
         err_total++;
         close_out();
      end
   end

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic xfer(input logic [3:0] cmd, input logic [11:0] code);
      u_host.send({cmd, code}, 16, rx);
   endtask
   task automatic both(input logic [11:0] a, b);
      chk("dac_a", {4'h0, dac_a_code}, {4'h0, a});
      chk("dac_b", {4'h0, dac_b_code}, {4'h0, b});
   endtask
   // pin pulse long enough to pass the input filter
   task automatic pulse(input bit clr);
      @(negedge sys_clk);
      if (clr) hardware_clear_n = 1'b0;
      else load_output_n = 1'b0;
      repeat (10) @(negedge sys_clk);
      hardware_clear_n = 1'b1;
      load_output_n = 1'b1;
      repeat (8) @(negedge sys_clk);
   endtask

   task automatic t_async();
      xfer(`DSI_CMD_LDI_A, 12'h400);
      chk("hold_a", {4'h0, dac_a_code}, 16'h0);
      xfer(`DSI_CMD_LDU_AB, 12'hfff);
      both(12'hfff, 12'hfff);
      xfer(`DSI_CMD_LDU_A, 12'h123);
      xfer(`DSI_CMD_LDU_B, 12'h456);
      both(12'h123, 12'h456);
   endtask
   task automatic t_sync();
      xfer(`DSI_CMD_LDI_A, 12'hc00);
      xfer(`DSI_CMD_LDI_B, 12'h321);
      both(12'h123, 12'h456);
      pulse(1'b0);
      both(12'hc00, 12'h321);
      xfer(`DSI_CMD_LDI_AB, 12'h0f0);
      pulse(1'b0);
      both(12'h0f0, 12'h0f0);
   endtask
   task automatic t_clear();
      xfer(`DSI_CMD_CLR_MID, 12'h000);
      both(12'h800, 12'h800);
      xfer(`DSI_CMD_CLR_ZERO, 12'h000);
      both(12'h000, 12'h000);
      xfer(`DSI_CMD_LDU_AB, 12'h777);
      pulse(1'b1);
      both(12'h000, 12'h000);
      xfer(`DSI_CMD_CTRL, 12'h002);
      xfer(`DSI_CMD_LDU_AB, 12'h777);
      pulse(1'b1);
      both(12'h800, 12'h800);
   endtask
   // rising-edge sampling: a write lands and chained bits leave on falls
   task automatic t_edge();
      xfer(`DSI_CMD_CTRL, 12'h004);
      host_rise = 1'b1;
      xfer(`DSI_CMD_LDU_B, 12'h5a5);
      chk("edge_prev", rx, {`DSI_CMD_CTRL, 12'h004});
      chk("edge_b", {4'h0, dac_b_code}, 16'h05a5);
      xfer(`DSI_CMD_CTRL, 12'h000);
      chk("edge_chain", rx, {`DSI_CMD_LDU_B, 12'h5a5});
      host_rise = 1'b0;
   endtask
   // readback, chaining, a short frame, then chaining off
   task automatic t_link();
      xfer(`DSI_CMD_LDU_A, 12'habc);
      xfer(`DSI_CMD_LDU_B, 12'hdef);
      xfer(`DSI_CMD_RB_A, 12'h000);
      xfer(`DSI_CMD_RB_B, 12'h000);
      chk("rb_a", rx, 16'h0abc);
      xfer(`DSI_CMD_NOP, 12'h5a3);
      chk("rb_b", rx, 16'h0def);
      xfer(`DSI_CMD_NOP, 12'h000);
      chk("chain", rx, 16'h05a3);
      u_host.send({`DSI_CMD_LDU_A, 12'h111}, 15, rx);
      both(12'habc, 12'hdef);
      xfer(`DSI_CMD_CTRL, 12'h001);
      xfer(`DSI_CMD_NOP, 12'hfff);
      chk("chain_off", rx, 16'h0000);
   endtask

   // reset, then each scenario in turn
   initial begin
      host_rise = 1'b0;
      rst_b = 1'b0;
      load_output_n = 1'b1;
      hardware_clear_n = 1'b1;
      err_total = 0;
      total_checks = 0;
      cyc = 0;
      repeat (3) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      both(12'h000, 12'h000);
      chk("sdo", {15'h0, serial_data_out}, 16'h0);
      t_async();
      t_sync();
      t_clear();
      t_edge();
      t_link();
      close_out();
   end
endmodule
